// [rtl/adc_channel_calibration.sv]
// Real-time correction datapath: offset subtract, gain multiply, phase delay.
// Assumes raw results arrive one channel per strobe, synchronous to clk_sys,
// and that the modulator tick marks one sampling instant for phase counting.
// Operation
// - Each channel's stored offset (upper part and upper byte of lower part) is subtracted from every result unless its DC block is enabled.
// - The offset-corrected result is multiplied by the channel's stored gain factor.
// - Each channel's phase delay field shifts its sampling against the reference channel.
// - The DC blocking filter may be enabled instead of offset registers to remove offset.
`timescale 1ns/100ps
module adc_channel_calibration (
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic        cfg_wr,
  input  wire logic [1:0]  cfg_chan,
  input  wire logic [2:0]  cfg_sel,
  input  wire logic [15:0] cfg_wdata,
  output logic      [15:0] cfg_rdata,
  input  wire logic        mod_tick,
  output logic      [3:0]  sample_req,
  input  wire logic        raw_valid,
  input  wire logic [1:0]  raw_chan,
  input  wire logic [23:0] raw_data,
  output logic             out_valid,
  output logic      [1:0]  out_chan,
  output logic      [23:0] out_data
);
  localparam int N  = adc_calib_pkg::NUM_CHAN;
  localparam int W  = adc_calib_pkg::SAMPLE_W;
  localparam int PW = adc_calib_pkg::PHASE_W;

  // Register selects on the configuration port
  localparam logic [2:0] SEL_OFS_UP  = 3'h0;
  localparam logic [2:0] SEL_OFS_LO  = 3'h1;
  localparam logic [2:0] SEL_GAIN_UP = 3'h2;
  localparam logic [2:0] SEL_GAIN_LO = 3'h3;
  localparam logic [2:0] SEL_SETUP   = 3'h4;

  typedef enum logic [1:0] {ST_IDLE, ST_SUB, ST_MUL} pipe_state_t;

  logic [15:0] ofs_up_reg [N];
  logic [15:0] ofs_lo_reg [N];
  logic [15:0] gain_up_reg [N];
  logic [15:0] gain_lo_reg [N];
  logic [15:0] setup_reg [N];
  logic [15:0] ofs_up_next [N];
  logic [15:0] ofs_lo_next [N];
  logic [15:0] gain_up_next [N];
  logic [15:0] gain_lo_next [N];
  logic [15:0] setup_next [N];
  logic [PW-1:0] phase_cnt_reg [N];
  logic [PW-1:0] phase_cnt_next [N];
  logic [3:0]    armed_reg;
  logic [3:0]    armed_next;
  logic [W-1:0]  dc_est_reg [N];
  logic [W-1:0]  dc_est_next [N];

  pipe_state_t        st_reg;
  pipe_state_t        st_next;
  logic [1:0]         ch_reg;
  logic [1:0]         ch_next;
  logic signed [W:0]  diff_reg;
  logic signed [W:0]  diff_next;
  logic [W-1:0]       gain_snap_reg;
  logic [W-1:0]       gain_snap_next;
  logic               out_valid_next;
  logic [1:0]         out_chan_next;
  logic [W-1:0]       out_data_next;

  // Saturate a wide signed value into the 24-bit result range
  function automatic logic [W-1:0] sat24(input logic signed [W+25:0] v);
    logic signed [W+25:0] hi;
    logic signed [W+25:0] lo;
    hi = (W+26)'(24'sh7fffff);
    lo = -(W+26)'(24'sh7fffff) - (W+26)'(1);
    if (v > hi) begin
      sat24 = 24'h7fffff;
    end else if (v < lo) begin
      sat24 = 24'h800000;
    end else begin
      sat24 = v[W-1:0];
    end
  endfunction

  // Join an upper and lower register pair into one 24-bit word
  function automatic logic [W-1:0] join24(input logic [15:0] up, input logic [15:0] lo);
    join24 = {up, lo[15:adc_calib_pkg::UPPER_LSB]};
  endfunction

  // Host writes land in the register file on the cycle after cfg_wr
  always_comb begin
    for (int i = 0; i < N; i++) begin
      ofs_up_next[i]  = ofs_up_reg[i];
      ofs_lo_next[i]  = ofs_lo_reg[i];
      gain_up_next[i] = gain_up_reg[i];
      gain_lo_next[i] = gain_lo_reg[i];
      setup_next[i]   = setup_reg[i];
      if (cfg_wr && (cfg_chan == 2'(i))) begin
        case (cfg_sel)
          SEL_OFS_UP:  ofs_up_next[i]  = cfg_wdata;
          SEL_OFS_LO:  ofs_lo_next[i]  = cfg_wdata;
          SEL_GAIN_UP: gain_up_next[i] = cfg_wdata;
          SEL_GAIN_LO: gain_lo_next[i] = cfg_wdata;
          SEL_SETUP:   setup_next[i]   = cfg_wdata;
          default:     ;
        endcase
      end
    end
  end

  // Readback of the addressed register; unknown selects read zero
  always_comb begin
    case (cfg_sel)
      SEL_OFS_UP:  cfg_rdata = ofs_up_reg[cfg_chan];
      SEL_OFS_LO:  cfg_rdata = ofs_lo_reg[cfg_chan];
      SEL_GAIN_UP: cfg_rdata = gain_up_reg[cfg_chan];
      SEL_GAIN_LO: cfg_rdata = gain_lo_reg[cfg_chan];
      SEL_SETUP:   cfg_rdata = setup_reg[cfg_chan];
      default:     cfg_rdata = 16'h0000;
    endcase
  end

  // Phase delay: each channel samples the programmed number of clk_sys cycles plus one after the tick
  always_comb begin
    sample_req = 4'h0;
    for (int i = 0; i < N; i++) begin
      phase_cnt_next[i] = phase_cnt_reg[i];
      armed_next[i]     = armed_reg[i];
      if (mod_tick) begin
        // Reference tick restarts the delay from the live setting
        phase_cnt_next[i] = setup_reg[i][adc_calib_pkg::PHASE_POS +: PW];
        armed_next[i]     = 1'b1;
      end else if (armed_reg[i] && phase_cnt_reg[i] != '0) begin
        phase_cnt_next[i] = phase_cnt_reg[i] - PW'(1);
      end
      if (armed_reg[i] && phase_cnt_reg[i] == '0 && !mod_tick) begin
        sample_req[i] = 1'b1;
        armed_next[i] = 1'b0;
      end
    end
  end

  // Pipeline: capture, subtract offset, multiply by gain
  always_comb begin
    logic signed [W+25:0] prod;
    logic signed [W:0]    raw_s;
    logic signed [W:0]    corr;
    prod           = '0;
    raw_s          = {raw_data[W-1], raw_data};
    corr           = '0;
    st_next        = st_reg;
    ch_next        = ch_reg;
    diff_next      = diff_reg;
    gain_snap_next = gain_snap_reg;
    out_valid_next = 1'b0;
    out_chan_next  = out_chan;
    out_data_next  = out_data;
    for (int i = 0; i < N; i++) begin
      dc_est_next[i] = dc_est_reg[i];
    end
    case (st_reg)
      ST_IDLE: begin
        if (raw_valid) begin
          ch_next = raw_chan;
          if (setup_reg[raw_chan][adc_calib_pkg::DCBLK_POS]) begin
            // DC block: track the mean with a leaky integrator and remove it
            corr = {dc_est_reg[raw_chan][W-1], dc_est_reg[raw_chan]};
            dc_est_next[raw_chan] = dc_est_reg[raw_chan]
              + W'((raw_s - corr) >>> adc_calib_pkg::DCBLK_SHIFT);
          end else begin
            corr = {ofs_up_reg[raw_chan][15],
                    join24(ofs_up_reg[raw_chan], ofs_lo_reg[raw_chan])};
          end
          diff_next = raw_s - corr;
          // Gain taken here so a write mid-pipeline does not split a sample
          gain_snap_next = join24(gain_up_reg[raw_chan], gain_lo_reg[raw_chan]);
          st_next = ST_SUB;
        end
      end
      ST_SUB: begin
        st_next = ST_MUL;
      end
      ST_MUL: begin
        prod = ((W+26)'(diff_reg) * $signed({1'b0, gain_snap_reg}))
               >>> adc_calib_pkg::GAIN_FRAC_W;
        out_data_next  = sat24(prod);
        out_chan_next  = ch_reg;
        out_valid_next = 1'b1;
        st_next        = ST_IDLE;
      end
      default: st_next = ST_IDLE;
    endcase
  end

  // Registers only; held values stay until the next result replaces them
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < N; i++) begin
        ofs_up_reg[i]    <= adc_calib_pkg::OFFSET_UPPER_RST;
        ofs_lo_reg[i]    <= adc_calib_pkg::OFFSET_LOWER_RST;
        gain_up_reg[i]   <= adc_calib_pkg::GAIN_UPPER_RST;
        gain_lo_reg[i]   <= adc_calib_pkg::GAIN_LOWER_RST;
        setup_reg[i]     <= adc_calib_pkg::SETUP_RST;
        phase_cnt_reg[i] <= '0;
        dc_est_reg[i]    <= '0;
      end
      armed_reg     <= 4'h0;
      st_reg        <= ST_IDLE;
      ch_reg        <= 2'h0;
      diff_reg      <= '0;
      gain_snap_reg <= '0;
      out_valid     <= 1'b0;
      out_chan      <= 2'h0;
      out_data      <= 24'h000000;
    end else begin
      for (int i = 0; i < N; i++) begin
        ofs_up_reg[i]    <= ofs_up_next[i];
        ofs_lo_reg[i]    <= ofs_lo_next[i];
        gain_up_reg[i]   <= gain_up_next[i];
        gain_lo_reg[i]   <= gain_lo_next[i];
        setup_reg[i]     <= setup_next[i];
        phase_cnt_reg[i] <= phase_cnt_next[i];
        dc_est_reg[i]    <= dc_est_next[i];
      end
      armed_reg     <= armed_next;
      st_reg        <= st_next;
      ch_reg        <= ch_next;
      diff_reg      <= diff_next;
      gain_snap_reg <= gain_snap_next;
      out_valid     <= out_valid_next;
      out_chan      <= out_chan_next;
      out_data      <= out_data_next;
    end
  end
endmodule

// [rtl/adc_calib_pkg.sv]
// Shared constants for the per-channel conversion correction datapath.
// Assumes 24-bit two's-complement conversion results and four channels.
package adc_calib_pkg;
  localparam int NUM_CHAN      = 4;
  localparam int SAMPLE_W      = 24;
  localparam int HALF_W        = 16;   // Width of each upper/lower register part
  localparam int UPPER_LSB     = 8;    // Upper part holds result bits 23:8
  localparam int GAIN_FRAC_W   = 23;   // Gain factor 1.23 unsigned, 0x800000 is unity
  localparam int PHASE_W       = 10;   // Phase delay in clk_sys cycles after the modulator tick
  localparam int PHASE_POS     = 6;    // Phase field position in the setup word
  localparam int DCBLK_POS     = 0;    // DC block enable bit in the setup word
  localparam logic [15:0] OFFSET_UPPER_RST = 16'h0000;
  localparam logic [15:0] OFFSET_LOWER_RST = 16'h0000;
  localparam logic [15:0] GAIN_UPPER_RST   = 16'h8000;
  localparam logic [15:0] GAIN_LOWER_RST   = 16'h0000;
  localparam logic [15:0] SETUP_RST        = 16'h0000;
  localparam int DCBLK_SHIFT   = 10;   // DC block filter corner, 2^-10 per sample
endpackage

// [verification/calib_props.sv]
// Checker on the correction datapath ports.
// Assumes raw strobes come three or more cycles apart.
`timescale 1ns/100ps
module calib_props (
  input wire logic        clk_sys,
  input wire logic        rst_n,
  input wire logic        cfg_wr,
  input wire logic [1:0]  cfg_chan,
  input wire logic [2:0]  cfg_sel,
  input wire logic [15:0] cfg_wdata,
  input wire logic [15:0] cfg_rdata,
  input wire logic        mod_tick,
  input wire logic [3:0]  sample_req,
  input wire logic        raw_valid,
  input wire logic [1:0]  raw_chan,
  input wire logic        out_valid,
  input wire logic [1:0]  out_chan,
  input wire logic [23:0] out_data
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // Fixed three-cycle pipeline, channel carried along
  lat_fixed_a: assert property (raw_valid |-> ##3 out_valid) else $error("late result");
  chan_kept_a: assert property (out_valid |-> out_chan == $past(raw_chan, 3))
    else $error("wrong channel");
  // Delivered results never rewritten between strobes
  data_held_a: assert property (!out_valid |-> $stable(out_data)) else $error("data moved");
  one_pulse_a: assert property (out_valid |=> !out_valid) else $error("long strobe");
  // A new setting is visible on the following cycle
  wr_seen_a: assert property (cfg_wr && cfg_sel < 3'h5 ##1
    ($stable(cfg_chan) && $stable(cfg_sel)) |-> cfg_rdata == $past(cfg_wdata))
    else $error("write lost");
  // No request is raised on a tick cycle; the tick restarts the delay instead
  tick_quiet_a: assert property (mod_tick |-> sample_req == 4'h0) else $error("req on tick");
endmodule
bind adc_channel_calibration calib_props calib_props_i (.clk_sys(clk_sys), .rst_n(rst_n),
  .cfg_wr(cfg_wr), .cfg_chan(cfg_chan), .cfg_sel(cfg_sel), .cfg_wdata(cfg_wdata),
  .cfg_rdata(cfg_rdata), .mod_tick(mod_tick), .sample_req(sample_req),
  .raw_valid(raw_valid), .raw_chan(raw_chan), .out_valid(out_valid),
  .out_chan(out_chan), .out_data(out_data));

// [verification/host_model.sv]
// Host stand-in that programs the calibration words.
// Assumes changes follow rising edges of clk_sys.
`timescale 1ns/100ps
module host_model (
  input  wire logic        clk_sys,
  input  wire logic [15:0] cfg_rdata,
  output logic             cfg_wr,
  output logic      [1:0]  cfg_chan,
  output logic      [2:0]  cfg_sel,
  output logic      [15:0] cfg_wdata
);
  initial begin
    cfg_wr = 1'b0;
    cfg_chan = 2'h0;
    cfg_sel = 3'h0;
    cfg_wdata = 16'h0000;
  end
  // One-cycle strobe; select kept so readback can follow
  task automatic wr(input logic [1:0] c, input logic [2:0] s, input logic [15:0] d);
    @(posedge clk_sys);
    cfg_wr <= 1'b1;
    cfg_chan <= c;
    cfg_sel <= s;
    cfg_wdata <= d;
    @(posedge clk_sys);
    cfg_wr <= 1'b0;
  endtask
  // Readback is combinational; sampled once settled
  task automatic rd(input logic [1:0] c, input logic [2:0] s, output logic [15:0] d);
    @(posedge clk_sys);
    cfg_chan <= c;
    cfg_sel <= s;
    #1 d = cfg_rdata;
  endtask
endmodule

// [verification/adc_channel_calibration_tb.sv]
// Self-checking bench for the correction datapath.
// Assumes host_model drives the config port; bench drives samples.
`timescale 1ns/100ps
module adc_channel_calibration_tb;
  logic        clk_sys, rst_n, cfg_wr, mod_tick, raw_valid, out_valid;
  logic [1:0]  cfg_chan, raw_chan, out_chan;
  logic [2:0]  cfg_sel;
  logic [3:0]  sample_req;
  logic [15:0] cfg_wdata, cfg_rdata, rd_val;
  logic [23:0] raw_data, out_data;
  int          errors, checks, cycles;
  adc_channel_calibration adc_channel_calibration_i (.clk_sys(clk_sys), .rst_n(rst_n),
    .cfg_wr(cfg_wr), .cfg_chan(cfg_chan), .cfg_sel(cfg_sel), .cfg_wdata(cfg_wdata),
    .cfg_rdata(cfg_rdata), .mod_tick(mod_tick), .sample_req(sample_req),
    .raw_valid(raw_valid), .raw_chan(raw_chan), .raw_data(raw_data),
    .out_valid(out_valid), .out_chan(out_chan), .out_data(out_data));
  host_model host_model_i (.clk_sys(clk_sys), .cfg_rdata(cfg_rdata), .cfg_wr(cfg_wr),
    .cfg_chan(cfg_chan), .cfg_sel(cfg_sel), .cfg_wdata(cfg_wdata));
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  task automatic summarize;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // Hang guard, far beyond the roughly 80 cycles needed
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 2000) begin
      errors++;
      $display("unexpected at %0t: run did not finish in time", $time);
      summarize;
    end
  end
  task automatic cmp(input logic [23:0] got, input logic [23:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // Reference: saturate(((raw - offset) * gain) >>> 23)
  function automatic logic [23:0] calc(input logic [23:0] r, o, g);
    logic signed [49:0] p;
    p = ($signed({r[23], r}) - $signed({o[23], o})) * $signed({1'b0, g});
    p = p >>> 23;
    if (p[49:23] != {27{p[23]}}) return p[49] ? 24'h800000 : 24'h7fffff;
    return p[23:0];
  endfunction
  task automatic send(input logic [1:0] c, input logic [23:0] r);
    @(posedge clk_sys);
    raw_valid <= 1'b1;
    raw_chan <= c;
    raw_data <= r;
    @(posedge clk_sys);
    raw_valid <= 1'b0;
  endtask
  task automatic expect_out(input logic [1:0] c, input logic [23:0] e);
    #1;
    for (int i = 0; i < 6 && out_valid !== 1'b1; i++) @(posedge clk_sys) #1;
    cmp({23'h0, out_valid}, 24'h1);
    cmp({22'h0, out_chan}, {22'h0, c});
    cmp(out_data, e);
  endtask
  task automatic chk(input logic [1:0] c, input logic [23:0] r, o, g);
    send(c, r);
    expect_out(c, calc(r, o, g));
  endtask
  initial begin
    rst_n = 1'b0;
    mod_tick = 1'b0;
    raw_valid = 1'b0;
    raw_chan = 2'h0;
    raw_data = 24'h0;
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'b1;
    host_model_i.rd(2'h0, 3'h2, rd_val);
    cmp({8'h0, rd_val}, 24'h008000);
    // Reserved select: write dropped, reads zero
    host_model_i.wr(2'h0, 3'h6, 16'hffff);
    host_model_i.rd(2'h0, 3'h6, rd_val);
    cmp({8'h0, rd_val}, 24'h0);
    // Lower offset part: only its upper byte joins the word, low byte stored
    host_model_i.wr(2'h0, 3'h1, 16'h80a5);
    host_model_i.rd(2'h0, 3'h1, rd_val);
    cmp({8'h0, rd_val}, 24'h0080a5);
    chk(2'h0, 24'h000100, 24'h000080, 24'h800000);
    host_model_i.wr(2'h1, 3'h0, 16'h0001);
    chk(2'h1, 24'h0003e8, 24'h000100, 24'h800000);
    host_model_i.wr(2'h1, 3'h2, 16'h4000);
    chk(2'h1, 24'h0003e8, 24'h000100, 24'h400000);
    // Offset changed while a sample is in flight
    send(2'h1, 24'h0007d0);
    host_model_i.wr(2'h1, 3'h0, 16'h0002);
    expect_out(2'h1, calc(24'h0007d0, 24'h000100, 24'h400000));
    chk(2'h1, 24'h0007d0, 24'h000200, 24'h400000);
    // Largest gain drives both ends into saturation
    host_model_i.wr(2'h2, 3'h2, 16'hffff);
    host_model_i.wr(2'h2, 3'h3, 16'hff00);
    chk(2'h2, 24'h600000, 24'h0, 24'hffffff);
    chk(2'h2, 24'ha00000, 24'h0, 24'hffffff);
    host_model_i.wr(2'h3, 3'h0, 16'h1000);
    host_model_i.wr(2'h3, 3'h4, 16'h0001);
    chk(2'h3, 24'h0, 24'h0, 24'h800000);
    // Estimate follows the input by one 1024th of the error per result
    chk(2'h3, 24'h004000, 24'h0, 24'h800000);
    chk(2'h3, 24'h004000, 24'h000010, 24'h800000);
    // Channel 0 stays the zero-phase reference
    host_model_i.wr(2'h2, 3'h4, 16'h00c0);
    @(posedge clk_sys);
    mod_tick <= 1'b1;
    @(posedge clk_sys);
    mod_tick <= 1'b0;
    for (int k = 1; k < 6; k++) begin
      #1 cmp({20'h0, sample_req}, k == 1 ? 24'hb : k == 4 ? 24'h4 : 24'h0);
      @(posedge clk_sys);
    end
    summarize;
  end
endmodule
